/* File: hw/pgwd_defs.vh */
`ifndef PGWD_DEFS_VH
`define PGWD_DEFS_VH

// register command codes
`define OFS_PG_MAP 8'hD4
`define OFS_PG_DELAY 8'hE1
`define OFS_WD_FIRST 8'hE2
`define OFS_WD_REPEAT 8'hE3

// reset values
`define RST_PG_MAP 16'h0000
`define RST_PG_DELAY 16'hEB20
`define RST_WD_FIRST 16'h8000
`define RST_WD_REPEAT 16'h8000

// power_good_source_map fields
`define MAP_WDOG_BIT 8
`define MAP_CHAN_HI 3
`define MAP_CHAN_LO 0

// linear format fields
`define LIN_EXP_HI 15
`define LIN_EXP_LO 11
`define LIN_MANT_HI 10
`define LIN_MANT_LO 0

// timing: one tick is 10 us at every timer
`define CLK_PERIOD_NS 50
`define TICK_NS 10000
`define DEGLITCH_NS 20000
`define ABSENT_TICKS 2
// divider value that follows a fall seen through the two-flop synchroniser
`define SHARE_FALL_PHASE 16'h0004

// conversion of milliseconds into internal steps, and clamps
`define PG_STEPS_PER_MS 8'h05
`define PG_STEP_LIMIT 24'h00FFDC
`define PG_TICKS_PER_STEP 24'h000014
`define WDF_STEPS_PER_MS 8'h01
`define WDF_STEP_LIMIT 24'h00FDE8
`define WDF_TICKS_PER_STEP 24'h000064
`define WDR_STEPS_PER_MS 8'h64
`define WDR_STEP_LIMIT 24'h00FFDC

`endif

/* File: hw/power_good_watchdog_sync.v */
`timescale 1ns/1ps
// Contract
// - wired shared clock, fastest wins, sync falling
// - hold shared clock low while input voltage low
// - held-low shared clock disables channels after deglitch
// - shared clock release starts a start sequence
// - map bit 8 ANDs watchdog status in
// - map bits 3..0 AND channel status in
// - reserved map bits read zero
// - assert power good after programmed delay
// - delay counts shared clock, else internal oscillator
// - delay clamped 13.1 s, 200 us steps
// - delay register reads back raw written value
// - off-uses-undervoltage set: fast undervoltage comparator
// - off-uses-undervoltage clear: slow power-good-off poll
// - nonzero repeat-interval write restarts watchdog
// - kick input rising edge restarts watchdog
// - expiry asserts alert, drops and reasserts power good
// - zero in either interval disables watchdog
// - both intervals reset to zero milliseconds
// - first interval after power good or enable
// - first interval clamped 65 s, 1 ms steps
// - repeat interval clamped 655 ms, 10 us
// - watchdog runs on internal clock only
`include "pgwd_defs.vh"

module power_good_watchdog_sync #(
  parameter integer TICK_CYC = `TICK_NS / `CLK_PERIOD_NS,
  parameter integer DEGLITCH_CYC = `DEGLITCH_NS / `CLK_PERIOD_NS
) (
  input wire clk,
  input wire reset_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire vin_share_enable,
  input wire power_good_off_uses_undervoltage,
  input wire vin_insufficient,
  input wire [3:0] chan_power_good_on,
  input wire [3:0] chan_uv_fast_fault,
  input wire [3:0] chan_pg_off_polled,
  input wire watchdog_kick_input,
  input wire alert_clear,
  input wire share_clk_in,
  output reg share_clk_out,
  output reg share_clk_oe,
  output reg power_good,
  output reg alert_output_n,
  output reg channels_disable,
  output reg start_sequence
);

  // watchdog states
  localparam [1:0] WD_IDLE = 2'b00;
  localparam [1:0] WD_FIRST = 2'b01;
  localparam [1:0] WD_REPEAT = 2'b10;
  localparam [1:0] WD_EXPIRED = 2'b11;
  localparam integer TICK_LAST_I = TICK_CYC - 1;
  localparam integer DEGLITCH_LAST_I = DEGLITCH_CYC - 1;
  localparam integer HALF_TICK_I = TICK_CYC / 2;
  // counters are 16 bits wide, so the counts are cut to that on purpose
  localparam [15:0] TICK_LAST = TICK_LAST_I[15:0];
  localparam [15:0] DEGLITCH_LAST = DEGLITCH_LAST_I[15:0];
  localparam [15:0] HALF_TICK = HALF_TICK_I[15:0];

  // linear value to internal steps, rounded, clamped
  function [23:0] lin_steps;
    input [15:0] v;
    input [7:0] scale;
    input [23:0] lim;
    reg signed [4:0] e;
    reg [10:0] m;
    reg [47:0] p;
    reg [4:0] n;
    begin
      e = v[`LIN_EXP_HI:`LIN_EXP_LO];
      m = v[`LIN_MANT_HI:`LIN_MANT_LO];
      p = {37'h0, m} * {40'h0, scale};
      n = 5'h00;
      if (m[10]) begin // negative times read as zero
        p = 48'h0;
      end else if (!e[4]) begin
        p = p << e[3:0];
      end else begin
        n = -e;
        p = (p + ((48'h1 << n) >> 1)) >> n;
      end
      lin_steps = (p > {24'h0, lim}) ? lim : p[23:0];
    end
  endfunction

  // register storage; map keeps only implemented bits, the rest raw as written
  reg [4:0] map_q;
  reg [15:0] pg_delay_q;
  reg [15:0] wd_first_q;
  reg [15:0] wd_repeat_q;
  reg wd_write_kick_q; // nonzero write to repeat interval

  // register writes and readback
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      map_q <= 5'h00;
      pg_delay_q <= `RST_PG_DELAY;
      wd_first_q <= `RST_WD_FIRST;
      wd_repeat_q <= `RST_WD_REPEAT;
      wd_write_kick_q <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      wd_write_kick_q <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `OFS_PG_MAP: begin
            // only implemented bits stored
            map_q <= {reg_wdata[`MAP_WDOG_BIT], reg_wdata[`MAP_CHAN_HI:`MAP_CHAN_LO]};
          end
          `OFS_PG_DELAY: pg_delay_q <= reg_wdata;
          `OFS_WD_FIRST: wd_first_q <= reg_wdata;
          `OFS_WD_REPEAT: begin
            wd_repeat_q <= reg_wdata;
            wd_write_kick_q <= |reg_wdata;
          end
          default: ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `OFS_PG_MAP: reg_rdata <= {7'h00, map_q[4], 4'h0, map_q[3:0]};
          `OFS_PG_DELAY: reg_rdata <= pg_delay_q;
          `OFS_WD_FIRST: reg_rdata <= wd_first_q;
          `OFS_WD_REPEAT: reg_rdata <= wd_repeat_q;
          default: reg_rdata <= 16'h0000; // unknown codes read zero
        endcase
      end
    end
  end

  // decoded internal limits, all in 10 us ticks
  wire [23:0] pg_steps = lin_steps(pg_delay_q, `PG_STEPS_PER_MS, `PG_STEP_LIMIT);
  wire [47:0] pg_ticks_w = pg_steps * `PG_TICKS_PER_STEP;
  wire [23:0] pg_ticks = pg_ticks_w[23:0];
  wire [23:0] wdf_steps = lin_steps(wd_first_q, `WDF_STEPS_PER_MS, `WDF_STEP_LIMIT);
  wire [47:0] wdf_ticks_w = wdf_steps * `WDF_TICKS_PER_STEP;
  wire [23:0] wdf_ticks = wdf_ticks_w[23:0];
  wire [23:0] wdr_ticks = lin_steps(wd_repeat_q, `WDR_STEPS_PER_MS, `WDR_STEP_LIMIT);
  // a value rounding to zero also disables the timer
  wire wd_enabled = (wdf_ticks != 24'h0) && (wdr_ticks != 24'h0);

  // pin synchronisers; first stage feeds only the second
  reg [1:0] kick_sync_q;
  reg kick_prev_q;
  reg [1:0] share_sync_q;
  reg share_prev_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      kick_sync_q <= 2'b00;
      kick_prev_q <= 1'b0;
      share_sync_q <= 2'b11; // pulled-up idle line
      share_prev_q <= 1'b1;
    end else begin
      kick_sync_q <= {kick_sync_q[0], watchdog_kick_input};
      kick_prev_q <= kick_sync_q[1];
      share_sync_q <= {share_sync_q[0], share_clk_in};
      share_prev_q <= share_sync_q[1];
    end
  end
  // synced line level and its edges
  wire share_line = share_sync_q[1];
  wire kick_rise = kick_sync_q[1] & ~kick_prev_q;
  wire share_fall = share_prev_q & ~share_line;
  wire share_rise = ~share_prev_q & share_line;

  // own shared-clock generator, restarted by any falling edge
  reg [15:0] div_q;
  reg [15:0] lowcnt_q;
  reg [1:0] absent_q; // periods since last seen falling edge
  reg held_q; // line stuck low past deglitch
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 16'h0000;
      share_clk_oe <= 1'b0;
      share_clk_out <= 1'b0;
      lowcnt_q <= 16'h0000;
      absent_q <= 2'b00;
      held_q <= 1'b0;
      channels_disable <= 1'b0;
      start_sequence <= 1'b0;
    end else begin
      // a faster peer pulls the line first, so we fall in behind it
      if (share_fall) begin
        // the fall is seen late; jump to its true phase so one period stays one tick
        div_q <= `SHARE_FALL_PHASE;
      end else if (div_q == TICK_LAST) begin
        div_q <= 16'h0000;
      end else begin
        div_q <= div_q + 16'h0001;
      end
      // open drain: drive low in first half or while input is low
      share_clk_oe <= (div_q < HALF_TICK) | (vin_share_enable & vin_insufficient);
      share_clk_out <= 1'b0;
      // presence watch: no edge for a while means the line is dead
      if (share_fall) begin
        absent_q <= 2'b00;
      end else if (div_q == TICK_LAST && absent_q != `ABSENT_TICKS) begin
        absent_q <= absent_q + 2'b01;
      end
      // held-low detection with deglitch
      if (share_line) begin
        lowcnt_q <= 16'h0000;
      end else if (lowcnt_q != DEGLITCH_LAST) begin
        lowcnt_q <= lowcnt_q + 16'h0001;
      end
      start_sequence <= 1'b0;
      if (!vin_share_enable) begin
        held_q <= 1'b0;
        channels_disable <= 1'b0;
      end else if (!share_line && lowcnt_q == DEGLITCH_LAST) begin
        held_q <= 1'b1;
        channels_disable <= 1'b1;
      end else if (held_q && share_rise) begin
        // last chip to see its input good releases the line last
        held_q <= 1'b0;
        channels_disable <= 1'b0;
        start_sequence <= 1'b1;
      end
    end
  end
  // present while falls keep arriving
  wire share_present = (absent_q != `ABSENT_TICKS);
  wire osc_wrap = (div_q == TICK_LAST);
  // share tick when clock present, own oscillator otherwise
  wire pg_tick = share_present ? share_fall : osc_wrap;

  // watchdog's private 10 us divider, never reset by the line
  reg [15:0] wd_div_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_div_q <= 16'h0000;
    end else if (wd_div_q == TICK_LAST) begin
      wd_div_q <= 16'h0000;
    end else begin
      wd_div_q <= wd_div_q + 16'h0001;
    end
  end
  // one strobe per tick for both watchdog intervals
  wire wd_tick = (wd_div_q == TICK_LAST);

  // per-channel good status, off source chosen by config
  reg [3:0] chan_good_q;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          chan_good_q[gi] <= 1'b0;
        end else if (power_good_off_uses_undervoltage ? chan_uv_fast_fault[gi]
            : chan_pg_off_polled[gi]) begin
          chan_good_q[gi] <= 1'b0;
        end else if (chan_power_good_on[gi]) begin
          chan_good_q[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // watchdog timer
  reg [1:0] wd_state_q;
  reg [23:0] wd_cnt_q;
  // not-expired status, fed to power good
  wire wd_ok = (wd_state_q != WD_EXPIRED);
  wire wd_restart = kick_rise | wd_write_kick_q;
  // first period waits for power good only if watchdog is mapped in
  wire wd_arm = map_q[4] ? power_good : 1'b1;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_state_q <= WD_IDLE;
      wd_cnt_q <= 24'h000000;
    end else if (!wd_enabled) begin
      wd_state_q <= WD_IDLE;
      wd_cnt_q <= 24'h000000;
    end else begin
      case (wd_state_q)
        WD_IDLE: begin
          wd_cnt_q <= 24'h000000;
          if (wd_arm) begin
            wd_state_q <= WD_FIRST;
          end
        end
        WD_FIRST, WD_REPEAT: begin
          if (wd_restart) begin
            // a kick ends the first period too
            wd_state_q <= WD_REPEAT;
            wd_cnt_q <= 24'h000000;
          end else if (wd_tick) begin
            if (wd_cnt_q + 24'h000001 >= ((wd_state_q == WD_FIRST) ? wdf_ticks : wdr_ticks)) begin
              wd_state_q <= WD_EXPIRED;
            end
            wd_cnt_q <= wd_cnt_q + 24'h000001;
          end
        end
        WD_EXPIRED: begin
          // one cycle of not-ok drops power good, then rearm
          wd_state_q <= WD_IDLE;
          wd_cnt_q <= 24'h000000;
        end
        default: wd_state_q <= WD_IDLE;
      endcase
    end
  end

  // alert latch; expiry set wins over a clear in the same cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alert_output_n <= 1'b1;
    end else if (wd_state_q == WD_EXPIRED) begin
      alert_output_n <= 1'b0;
    end else if (alert_clear) begin
      alert_output_n <= 1'b1;
    end
  end

  // power good condition and assertion delay
  wire chans_ok = &(~map_q[3:0] | chan_good_q);
  wire wdog_ok = ~map_q[4] | wd_ok;
  wire pg_cond = chans_ok & wdog_ok;
  // assertion delay counter, in share or oscillator ticks
  reg [23:0] pg_cnt_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_cnt_q <= 24'h000000;
      power_good <= 1'b0;
    end else if (!pg_cond) begin
      // any loss drops the pin and restarts the wait
      pg_cnt_q <= 24'h000000;
      power_good <= 1'b0;
    end else if (pg_cnt_q >= pg_ticks) begin
      power_good <= 1'b1;
    end else if (pg_tick) begin
      pg_cnt_q <= pg_cnt_q + 24'h000001;
    end
  end

endmodule

/* File: test/pgwd_checker_sva.sv */
`timescale 1ns/1ps
// pin watcher; shadow copies of host writes feed the properties
module pgwd_checker #(
  parameter integer TICK_CYC = 200,
  parameter integer DEGLITCH_CYC = 400
) (
  input wire clk,
  input wire reset_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire vin_share_enable,
  input wire power_good_off_uses_undervoltage,
  input wire vin_insufficient,
  input wire [3:0] chan_pg_off_polled,
  input wire share_clk_in,
  input wire share_clk_oe,
  input wire power_good,
  input wire alert_output_n,
  input wire channels_disable,
  input wire start_sequence
);
  reg [15:0] map_q, dly_q, wdf_q, wdr_q; // last written values
  reg [9:0] low_q; // raw line low time, saturating
  // shadows follow writes; raw count runs ahead of the synced one
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      map_q <= 16'h0000;
      dly_q <= 16'hEB20;
      wdf_q <= 16'h8000;
      wdr_q <= 16'h8000;
      low_q <= 10'h000;
    end else begin
      if (reg_wr && reg_addr == 8'hD4) map_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'hE1) dly_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'hE2) wdf_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'hE3) wdr_q <= reg_wdata;
      low_q <= share_clk_in ? 10'h000 : low_q + {9'h000, ~&low_q};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_map_reserved: assert property (
    reg_rd && reg_addr == 8'hD4 |=> reg_rdata[15:9] == 7'h00 && reg_rdata[7:4] == 4'h0)
    else $error("reserved map bits set");
  chk_delay_echo: assert property (
    reg_rd && !reg_wr && reg_addr == 8'hE1 |=> reg_rdata == dly_q)
    else $error("delay readback differs");
  chk_wdog_drop: assert property (
    $fell(alert_output_n) && map_q[8] |-> ##[0:1] !power_good)
    else $error("power good kept on expiry");
  chk_vin_hold: assert property (
    (vin_share_enable && vin_insufficient) [*4] |-> share_clk_oe)
    else $error("line not held low");
  chk_hold_disable: assert property (
    vin_share_enable && low_q == DEGLITCH_CYC + 10 |-> channels_disable)
    else $error("channels not disabled");
  chk_start_release: assert property (
    $rose(share_clk_in) && channels_disable && vin_share_enable |-> ##[1:6] start_sequence)
    else $error("no start after release");
  chk_poll_drop: assert property (
    power_good && map_q[0] && chan_pg_off_polled[0] && !power_good_off_uses_undervoltage
      |-> ##[1:3] !power_good)
    else $error("polled off ignored");
  chk_wd_off: assert property (
    alert_output_n && (wdf_q[10:0] == 11'h000 || wdr_q[10:0] == 11'h000) |=> alert_output_n)
    else $error("alert with timer off");
endmodule

bind power_good_watchdog_sync pgwd_checker #(.TICK_CYC(TICK_CYC), .DEGLITCH_CYC(DEGLITCH_CYC))
  pgwd_checker_i (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .vin_share_enable, .power_good_off_uses_undervoltage, .vin_insufficient,
  .chan_pg_off_polled, .share_clk_in, .share_clk_oe, .power_good, .alert_output_n,
  .channels_disable, .start_sequence);

/* File: test/host_peer_model.sv */
`timescale 1ns/1ps
// supervised processor kicking the watchdog, plus a peer on the shared line
module host_peer_model (
  input wire clk,
  input wire kick_on,
  input wire [9:0] kick_gap,
  input wire peer_hold,
  input wire share_clk_oe,
  output reg watchdog_kick_input,
  output wire share_clk_in
);
  reg [9:0] cnt_q = 10'h000; // cycles since last rising kick
  // pull-up wins unless some party pulls low
  assign share_clk_in = ~(share_clk_oe | peer_hold);
  // one rising edge per gap; idle pin rests low
  always @(posedge clk) begin
    cnt_q <= (cnt_q >= kick_gap) ? 10'h000 : cnt_q + 10'h001;
    watchdog_kick_input <= kick_on && cnt_q < 10'h004;
  end
  initial watchdog_kick_input = 1'b0;
endmodule

/* File: test/power_good_watchdog_sync_bench.sv */
`timescale 1ns/1ps
module power_good_watchdog_sync_bench;
  reg clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, hit;
  reg [7:0] reg_addr = 8'h00;
  reg [15:0] reg_wdata = 16'h0000;
  reg vin_share_enable = 1'b0, power_good_off_uses_undervoltage = 1'b0, vin_insufficient = 1'b0;
  reg [3:0] chan_power_good_on = 4'h0, chan_uv_fast_fault = 4'h0, chan_pg_off_polled = 4'h0;
  reg alert_clear = 1'b0, kick_on = 1'b0, peer_hold = 1'b0;
  wire [15:0] reg_rdata;
  wire watchdog_kick_input, share_clk_in, share_clk_out, share_clk_oe, power_good;
  wire alert_output_n, channels_disable, start_sequence;
  logic [15:0] exp_q[$]; // noted read results, oldest first
  integer seed = 81, v, miscompares = 0, comparisons = 0, cyc = 0;
  // short tick and deglitch keep the run small
  power_good_watchdog_sync #(.TICK_CYC(10), .DEGLITCH_CYC(20)) power_good_watchdog_sync_i (
    .clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .vin_share_enable,
    .power_good_off_uses_undervoltage, .vin_insufficient, .chan_power_good_on,
    .chan_uv_fast_fault, .chan_pg_off_polled, .watchdog_kick_input, .alert_clear,
    .share_clk_in, .share_clk_out, .share_clk_oe, .power_good, .alert_output_n,
    .channels_disable, .start_sequence);
  host_peer_model host_peer_model_i (.clk, .kick_on, .kick_gap(10'h0C8), .peer_hold,
    .share_clk_oe, .watchdog_kick_input, .share_clk_in);
  always #25 clk = ~clk;
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons = comparisons + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task pin(input string n, input logic e, input logic s);
    chk(n, {15'h0000, e}, {15'h0000, s});
  endtask
  task conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // read results are matched one cycle after the strobe; hang guard too
  always @(posedge clk) begin
    if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    rd_d <= reg_rd;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      conclude();
    end
  end
  task wr(input [7:0] a, input [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // let the edge's updates land before looking
  task waitc(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'hD4, 16'h0000);
    rd(8'hE1, 16'hEB20);
    rd(8'hE2, 16'h8000);
    rd(8'hE3, 16'h8000);
    wr(8'hD4, 16'hFFFF);
    rd(8'hD4, 16'h010F);
    v = $random(seed);
    wr(8'hE1, v[15:0]);
    rd(8'hE1, v[15:0]);
    wr(8'h00, 16'hFFFF);
    rd(8'h00, 16'h0000);
    wr(8'hE1, 16'h0001);
    wr(8'hD4, 16'h0003);
    chan_power_good_on <= 4'h3;
    waitc(900);
    pin("power_good", 1'b0, power_good);
    waitc(200);
    pin("power_good", 1'b1, power_good);
    @(posedge clk);
    chan_pg_off_polled <= 4'h4;
    waitc(20);
    pin("power_good", 1'b1, power_good);
    @(posedge clk);
    chan_pg_off_polled <= 4'h1;
    waitc(5);
    pin("power_good", 1'b0, power_good);
    @(posedge clk);
    chan_pg_off_polled <= 4'h0;
    power_good_off_uses_undervoltage <= 1'b1;
    waitc(1100);
    pin("power_good", 1'b1, power_good);
    @(posedge clk);
    chan_uv_fast_fault <= 4'h2;
    waitc(5);
    pin("power_good", 1'b0, power_good);
    @(posedge clk);
    chan_uv_fast_fault <= 4'h0;
    wr(8'hE2, 16'h0001);
    wr(8'hE3, 16'hF801);
    wr(8'hD4, 16'h0103);
    kick_on <= 1'b1;
    waitc(3000);
    pin("alert_output_n", 1'b1, alert_output_n);
    pin("power_good", 1'b1, power_good);
    @(posedge clk);
    kick_on <= 1'b0;
    waitc(700);
    pin("alert_output_n", 1'b0, alert_output_n);
    pin("power_good", 1'b0, power_good);
    waitc(1100);
    pin("power_good", 1'b1, power_good);
    @(posedge clk);
    alert_clear <= 1'b1;
    @(posedge clk);
    alert_clear <= 1'b0;
    waitc(3);
    pin("alert_output_n", 1'b1, alert_output_n);
    repeat (4) begin
      waitc(400);
      wr(8'hE3, 16'hF801);
    end
    waitc(300);
    pin("alert_output_n", 1'b1, alert_output_n);
    wr(8'hE3, 16'h8000);
    waitc(1500);
    pin("alert_output_n", 1'b1, alert_output_n);
    @(posedge clk);
    vin_share_enable <= 1'b1;
    vin_insufficient <= 1'b1;
    waitc(40);
    pin("share_clk_oe", 1'b1, share_clk_oe);
    pin("share_clk_out", 1'b0, share_clk_out);
    pin("channels_disable", 1'b1, channels_disable);
    @(posedge clk);
    vin_insufficient <= 1'b0;
    peer_hold <= 1'b1;
    waitc(40);
    pin("channels_disable", 1'b1, channels_disable);
    @(posedge clk);
    peer_hold <= 1'b0;
    hit = 1'b0;
    repeat (20) begin
      waitc(1);
      if (start_sequence === 1'b1) hit = 1'b1;
    end
    pin("start_sequence", 1'b1, hit);
    conclude();
  end
endmodule
